/* hdl/xfer_ctrl_pkg.sv */
package xfer_ctrl_pkg;
    // ************************************************
    // register map (external data space)
    // ************************************************
    localparam logic [15:0] ADDR_COUNT_BYTE0   = 16'hf0d6;
    localparam logic [15:0] ADDR_COUNT_BYTE1   = 16'hf0d7;
    localparam logic [15:0] ADDR_COUNT_BYTE2   = 16'hf0d8;
    localparam logic [15:0] ADDR_COUNT_BYTE3   = 16'hf0d9;
    localparam logic [15:0] ADDR_CMD_LEN_CTRL  = 16'hf0da;
    // ************************************************
    // command length / bus control fields
    // ************************************************
    localparam int          CLC_LEN_LSB        = 0;
    localparam int          CLC_LEN_W          = 5;
    localparam int          CLC_DISABLE_BIT    = 5;
    localparam int          CLC_ABORT_BIT      = 6;
    localparam int          CLC_RSV_BIT        = 7;
    localparam logic [7:0]  COUNT_BYTE_RESET   = 8'h00;
    localparam logic [4:0]  CMD_LEN_RESET      = 5'h00;
    localparam logic        BUS_DISABLE_RESET  = 1'b1;
    localparam logic        ABORT_RESET        = 1'b0;
    // ************************************************
    // counters and staging
    // ************************************************
    localparam int          COUNT_W            = 32;
    localparam int          SECTOR_W           = 9;
    localparam int          SECTOR_LSB         = 9;
    localparam int          STAGING_BYTES      = 16;
    localparam logic [4:0]  ATA_FIRST_STAGE    = 5'h01;
    localparam logic [4:0]  ATA_LAST_STAGE     = 5'h07;
    localparam logic [4:0]  TRANS_IDLE         = 5'h00;
endpackage

/* hdl/xfer_down_counter.sv */
module xfer_down_counter
    import xfer_ctrl_pkg::*;
#(
    parameter int WIDTH = COUNT_W
)
(
    input  wire logic             clk_in,      // clock
    input  wire logic             rst_n_in,    // async reset
    input  wire logic             load_in,     // load pulse
    input  wire logic [WIDTH-1:0] load_val_in, // load value
    input  wire logic             dec_in,      // one byte moved
    output logic [WIDTH-1:0]      count_out    // current count
);
    if (WIDTH < 1)
    begin : g_width_check
        $error("counter width must be positive");
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } cnt_state_t;

    cnt_state_t s_r;
    cnt_state_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (load_in)
            s_nxt.count = load_val_in;
        else if (dec_in && (s_r.count != '0))
            s_nxt.count = s_r.count - WIDTH'(1);
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign count_out = s_r.count;
endmodule

/* hdl/xfer_count_bus_ctrl.sv */
// Overview of operation
// - byte at f0d8 holds count bits 23:16, read/write, resets to zero
// - byte at f0d9 holds count bits 31:24, read/write, resets to zero
// - packet length field used only for ATAPI drive in full-auto mode
// - ATAPI full-auto sends length-many staging bytes as command packet
// - ATA full-auto uses staging bytes one to seven, ignores length
// - bus-disable tri-states all drive outputs except reset during hard reset; resets to one
// - bus-disable touches only drivers, never the state machine
// - hard reset drives drive reset low despite bus-disable
// - abort bit 6 resets zero, acts only in semi/full-auto transfers
// - writing abort one returns transaction state machine to idle
// - count byte write loads both USB and drive counter sets
// - count reads pick USB or drive set by select bit
// - each set decrements as data moves, reaching zero at end
// - ATA PIO sector countdown starts from count bits 17:9
module xfer_count_bus_ctrl
    import xfer_ctrl_pkg::*;
(
    input  wire logic        CLK_IN,                 // 125 MHz clock
    input  wire logic        RST_N_IN,               // async reset, active low
    input  wire logic [15:0] ADDR_IN,                // external data address
    input  wire logic        WR_IN,                  // write strobe
    input  wire logic        RD_IN,                  // read strobe
    input  wire logic [7:0]  WDATA_IN,               // write data
    output logic [7:0]       RDATA_OUT,              // read data
    input  wire logic        FULL_AUTO_EN_IN,        // full-auto enable
    input  wire logic        SEMI_AUTO_EN_IN,        // semi-auto enable
    input  wire logic        ATAPI_DRIVE_IN,         // 1 atapi, 0 ata
    input  wire logic        PIO_MODE_IN,            // ata pio transfer
    input  wire logic        COUNT_SET_READ_SELECT_IN, // 1 drive set, 0 usb set
    input  wire logic        DRIVE_HARD_RESET_CTRL_IN, // hard reset control
    input  wire logic        USB_BYTE_DONE_IN,       // byte across usb
    input  wire logic        DRIVE_BYTE_DONE_IN,     // byte across drive bus
    input  wire logic        SECTOR_DONE_IN,         // one sector moved
    input  wire logic [4:0]  TRANS_STATE_IN,         // transaction state
    input  wire logic [15:0] DRIVE_BUS_OUT_IN,       // drive-side outputs from engine
    input  wire logic [15:0] DRIVE_BUS_OE_IN,        // drive-side enables from engine
    output logic [15:0]      DRIVE_BUS_OUT,          // drive-side pin values
    output logic [15:0]      DRIVE_BUS_OE_OUT,       // drive-side pin enables
    output logic             DRIVE_RESET_OUT,        // drive reset pin value
    output logic             DRIVE_RESET_OE_OUT,     // drive reset pin enable
    output logic             TRANSFER_ABORT_OUT,     // force transaction idle
    output logic [4:0]       COMMAND_PACKET_LENGTH_OUT, // packet bytes to send
    output logic [4:0]       STAGE_FIRST_OUT,        // first staging byte used
    output logic [4:0]       STAGE_LAST_OUT,         // last staging byte used
    output logic             STAGE_USE_VALID_OUT,    // staging range valid
    output logic [31:0]      USB_COUNT_OUT,          // usb counter set
    output logic [31:0]      DRIVE_COUNT_OUT,        // drive counter set
    output logic [8:0]       SECTOR_COUNTDOWN_OUT    // sector countdown
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [4:0]          cmd_len;
        logic                bus_disable;
        logic                abort;
        logic [SECTOR_W-1:0] sectors;
        logic [7:0]          rdata;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    logic                 count_load;
    logic [COUNT_W-1:0]   load_val;
    logic [COUNT_W-1:0]   usb_count;
    logic [COUNT_W-1:0]   drv_count;
    logic [COUNT_W-1:0]   read_set;
    logic                 auto_xfer;

    // ************************************************
    // elaboration checks
    // ************************************************
    // the length field must be able to name every staging byte
    if ((2 ** CLC_LEN_W) < STAGING_BYTES)
    begin : g_len_check
        $error("packet length field too narrow for staging bytes");
    end
    // the sector seed must lie inside the count
    if ((SECTOR_LSB + SECTOR_W) > COUNT_W)
    begin : g_sector_check
        $error("sector seed outside transfer count");
    end
    // the length field must stay below the bus-disable bit
    if ((CLC_LEN_LSB + CLC_LEN_W) > CLC_DISABLE_BIT)
    begin : g_field_check
        $error("length field overlaps bus-disable bit");
    end
    // the count must split into the four mapped bytes
    if (COUNT_W != 4 * 8)
    begin : g_count_check
        $error("transfer count must be four bytes wide");
    end

    // ************************************************
    // count byte write
    // ************************************************
    always_comb
    begin
        count_load = WR_IN && (ADDR_IN >= ADDR_COUNT_BYTE0) && (ADDR_IN <= ADDR_COUNT_BYTE3);
        // unwritten bytes keep the drive set value
        load_val   = drv_count;
        unique case (ADDR_IN)
            ADDR_COUNT_BYTE0: load_val[7:0]   = WDATA_IN;
            ADDR_COUNT_BYTE1: load_val[15:8]  = WDATA_IN;
            ADDR_COUNT_BYTE2: load_val[23:16] = WDATA_IN;
            ADDR_COUNT_BYTE3: load_val[31:24] = WDATA_IN;
            default:          load_val        = drv_count;
        endcase
    end

    xfer_down_counter #(.WIDTH(COUNT_W)) usb_cnt
    (
        .clk_in      (CLK_IN),
        .rst_n_in    (RST_N_IN),
        .load_in     (count_load),
        .load_val_in (load_val),
        .dec_in      (USB_BYTE_DONE_IN),
        .count_out   (usb_count)
    );

    xfer_down_counter #(.WIDTH(COUNT_W)) drv_cnt
    (
        .clk_in      (CLK_IN),
        .rst_n_in    (RST_N_IN),
        .load_in     (count_load),
        .load_val_in (load_val),
        .dec_in      (DRIVE_BYTE_DONE_IN),
        .count_out   (drv_count)
    );

    // ************************************************
    // register next state
    // ************************************************
    always_comb
    begin
        s_nxt     = s_r;
        auto_xfer = FULL_AUTO_EN_IN || SEMI_AUTO_EN_IN;
        read_set  = COUNT_SET_READ_SELECT_IN ? drv_count : usb_count;
        if (WR_IN && (ADDR_IN == ADDR_CMD_LEN_CTRL))
        begin
            s_nxt.cmd_len     = WDATA_IN[CLC_LEN_LSB +: CLC_LEN_W];
            s_nxt.bus_disable = WDATA_IN[CLC_DISABLE_BIT];
            s_nxt.abort       = WDATA_IN[CLC_ABORT_BIT];
        end
        if (count_load && PIO_MODE_IN)
            s_nxt.sectors = load_val[SECTOR_LSB +: SECTOR_W];
        else if (SECTOR_DONE_IN && (s_r.sectors != '0))
            s_nxt.sectors = s_r.sectors - 9'h001;
        s_nxt.rdata = 8'h00;
        if (RD_IN)
        begin
            unique case (ADDR_IN)
                ADDR_COUNT_BYTE0:   s_nxt.rdata = read_set[7:0];
                ADDR_COUNT_BYTE1:   s_nxt.rdata = read_set[15:8];
                ADDR_COUNT_BYTE2:   s_nxt.rdata = read_set[23:16];
                ADDR_COUNT_BYTE3:   s_nxt.rdata = read_set[31:24];
                ADDR_CMD_LEN_CTRL:
                begin
                    s_nxt.rdata[CLC_LEN_LSB +: CLC_LEN_W] = s_r.cmd_len;
                    s_nxt.rdata[CLC_DISABLE_BIT]          = s_r.bus_disable;
                    s_nxt.rdata[CLC_ABORT_BIT]            = s_r.abort;
                end
                default:            s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            s_r.cmd_len     <= CMD_LEN_RESET;
            s_r.bus_disable <= BUS_DISABLE_RESET;
            s_r.abort       <= ABORT_RESET;
            s_r.sectors     <= '0;
            s_r.rdata       <= 8'h00;
        end
        else
            s_r <= s_nxt;
    end

    // ************************************************
    // outputs
    // ************************************************
    assign RDATA_OUT       = s_r.rdata;
    assign USB_COUNT_OUT   = usb_count;
    assign DRIVE_COUNT_OUT = drv_count;
    assign SECTOR_COUNTDOWN_OUT = s_r.sectors;

    // abort to idle
    // a level, held until firmware clears it
    assign TRANSFER_ABORT_OUT = s_r.abort && auto_xfer;

    assign COMMAND_PACKET_LENGTH_OUT = (FULL_AUTO_EN_IN && ATAPI_DRIVE_IN) ? s_r.cmd_len : 5'h00;

    // atapi command packet or ata command block range
    // zero length wraps the last index; the valid flag masks it
    assign STAGE_FIRST_OUT     = ATAPI_DRIVE_IN ? 5'h00 : ATA_FIRST_STAGE;
    assign STAGE_LAST_OUT      = ATAPI_DRIVE_IN ? (s_r.cmd_len - 5'h01) : ATA_LAST_STAGE;
    assign STAGE_USE_VALID_OUT = FULL_AUTO_EN_IN && (!ATAPI_DRIVE_IN || (s_r.cmd_len != 5'h00));

    assign DRIVE_BUS_OUT    = DRIVE_BUS_OUT_IN;
    assign DRIVE_BUS_OE_OUT = s_r.bus_disable ? 16'h0000 : DRIVE_BUS_OE_IN;

    assign DRIVE_RESET_OUT    = !DRIVE_HARD_RESET_CTRL_IN;
    assign DRIVE_RESET_OE_OUT = DRIVE_HARD_RESET_CTRL_IN || !s_r.bus_disable;
endmodule

/* tb/xfer_count_bus_ctrl_assertions.sv */
module xfer_count_bus_ctrl_assertions
    import xfer_ctrl_pkg::*;
(
    input wire logic        CLK_IN,                    // clk
    input wire logic        RST_N_IN,                  // rst
    input wire logic [15:0] ADDR_IN,                   // addr
    input wire logic        WR_IN,                     // wr
    input wire logic        RD_IN,                     // rd
    input wire logic [7:0]  WDATA_IN,                  // wdata
    input wire logic [7:0]  RDATA_OUT,                 // rdata
    input wire logic        FULL_AUTO_EN_IN,           // full
    input wire logic        SEMI_AUTO_EN_IN,           // semi
    input wire logic        ATAPI_DRIVE_IN,            // atapi
    input wire logic        DRIVE_HARD_RESET_CTRL_IN,  // hard
    input wire logic [15:0] DRIVE_BUS_OE_OUT,          // oe
    input wire logic        DRIVE_RESET_OUT,           // rst pin
    input wire logic        DRIVE_RESET_OE_OUT,        // rst oe
    input wire logic        TRANSFER_ABORT_OUT,        // abort
    input wire logic [4:0]  COMMAND_PACKET_LENGTH_OUT, // len
    input wire logic [31:0] USB_COUNT_OUT,             // usb set
    input wire logic [31:0] DRIVE_COUNT_OUT            // drive set
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_oe_off; WR_IN && ADDR_IN == ADDR_CMD_LEN_CTRL && WDATA_IN[CLC_DISABLE_BIT]
        |=> DRIVE_BUS_OE_OUT == 16'h0000 && DRIVE_RESET_OE_OUT == DRIVE_HARD_RESET_CTRL_IN; endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus not released");
    property p_drive_hard_reset_ctrl; DRIVE_HARD_RESET_CTRL_IN |-> DRIVE_RESET_OE_OUT && !DRIVE_RESET_OUT; endproperty
    a_drive_hard_reset_ctrl: assert property (p_drive_hard_reset_ctrl) else $error("reset pin not low");
    property p_rsv_zero; RD_IN && ADDR_IN == ADDR_CMD_LEN_CTRL |=> !RDATA_OUT[CLC_RSV_BIT]; endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("bit 7 not zero");
    property p_rd_idle; !RD_IN |=> RDATA_OUT == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; RD_IN && ADDR_IN == 16'h0000 |=> RDATA_OUT == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_abort_mode; !FULL_AUTO_EN_IN && !SEMI_AUTO_EN_IN |-> !TRANSFER_ABORT_OUT; endproperty
    a_abort_mode: assert property (p_abort_mode) else $error("abort outside auto");
    property p_len_gate; !(FULL_AUTO_EN_IN && ATAPI_DRIVE_IN) |-> COMMAND_PACKET_LENGTH_OUT == 5'h00; endproperty
    a_len_gate: assert property (p_len_gate) else $error("length leaks");
    property p_load_both; WR_IN && ADDR_IN == ADDR_COUNT_BYTE3
        |=> USB_COUNT_OUT[31:24] == $past(WDATA_IN) && DRIVE_COUNT_OUT[31:24] == $past(WDATA_IN); endproperty
    a_load_both: assert property (p_load_both) else $error("sets not both loaded");
    c_abort: cover property (TRANSFER_ABORT_OUT);
    c_hard: cover property (DRIVE_HARD_RESET_CTRL_IN && DRIVE_RESET_OE_OUT);
    c_load: cover property (WR_IN && ADDR_IN == ADDR_COUNT_BYTE3);
endmodule
bind xfer_count_bus_ctrl xfer_count_bus_ctrl_assertions chk_u (.*);

/* tb/drive_model.sv */
module drive_model (
    input  wire logic [16:0] val_in,  // pin values, reset pin on top
    input  wire logic [16:0] oe_in,   // pin enables
    input  wire logic        clk_in,  // clock
    output logic [16:0]      lvl_out  // levels seen by the drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] last_r = 17'h00000;
    // released pins float: show inverse of last level
    always_comb lvl_out = (val_in & oe_in) | (~last_r & ~oe_in);
    always @(posedge clk_in) last_r <= lvl_out;
endmodule

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import xfer_ctrl_pkg::*;
    logic        CLK_IN = 1'h0, RST_N_IN = 1'h0, WR_IN, RD_IN, FULL_AUTO_EN_IN, SEMI_AUTO_EN_IN, ATAPI_DRIVE_IN;
    logic        PIO_MODE_IN, COUNT_SET_READ_SELECT_IN, DRIVE_HARD_RESET_CTRL_IN, USB_BYTE_DONE_IN;
    logic        DRIVE_BYTE_DONE_IN, SECTOR_DONE_IN, DRIVE_RESET_OUT, DRIVE_RESET_OE_OUT, TRANSFER_ABORT_OUT;
    logic        STAGE_USE_VALID_OUT, rd_seen = 1'h0;
    logic [15:0] ADDR_IN, DRIVE_BUS_OUT_IN, DRIVE_BUS_OE_IN, DRIVE_BUS_OUT, DRIVE_BUS_OE_OUT, lf = 16'hb33e;
    logic [7:0]  WDATA_IN, RDATA_OUT, exp_q[$];
    logic [4:0]  TRANS_STATE_IN, COMMAND_PACKET_LENGTH_OUT, STAGE_FIRST_OUT, STAGE_LAST_OUT;
    logic [31:0] USB_COUNT_OUT, DRIVE_COUNT_OUT, cnt, u;
    logic [8:0]  SECTOR_COUNTDOWN_OUT;
    logic [16:0] lvl;
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    xfer_count_bus_ctrl dut_u (.*);
    drive_model drv_u (.val_in({DRIVE_RESET_OUT, DRIVE_BUS_OUT}), .oe_in({DRIVE_RESET_OE_OUT, DRIVE_BUS_OE_OUT}),
        .clk_in(CLK_IN), .lvl_out(lvl));
    always #4 CLK_IN = ~CLK_IN;
    // ****************
    // helpers
    // ****************
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge CLK_IN);
        {ADDR_IN, WDATA_IN, WR_IN} = {a, d, 1'h1};
        @(negedge CLK_IN);
        WR_IN = 1'h0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge CLK_IN);
        {ADDR_IN, RD_IN} = {a, 1'h1};
        exp_q.push_back(e);
        @(negedge CLK_IN);
        RD_IN = 1'h0;
    endtask
    always @(posedge CLK_IN)
    begin
        rd_seen <= RD_IN;
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            stop_test;
        end
    end
    always @(negedge CLK_IN)
        if (rd_seen)
            chk("rdata", 32'(exp_q.pop_front()), 32'(RDATA_OUT));
    initial
    begin
        {WR_IN, RD_IN, FULL_AUTO_EN_IN, SEMI_AUTO_EN_IN, ATAPI_DRIVE_IN, PIO_MODE_IN, COUNT_SET_READ_SELECT_IN} = 7'h00;
        {DRIVE_HARD_RESET_CTRL_IN, USB_BYTE_DONE_IN, DRIVE_BYTE_DONE_IN, SECTOR_DONE_IN, TRANS_STATE_IN} = 9'h000;
        {ADDR_IN, WDATA_IN, DRIVE_BUS_OUT_IN, DRIVE_BUS_OE_IN} = {24'h000000, lf, 16'hffff};
        repeat (3) @(negedge CLK_IN);
        RST_N_IN = 1'h1;
        rd(ADDR_COUNT_BYTE2, 8'h00);
        rd(ADDR_COUNT_BYTE3, 8'h00);
        rd(ADDR_CMD_LEN_CTRL, 8'h20);
        chk("oe_rst", 32'h0, 32'(DRIVE_BUS_OE_OUT));
        PIO_MODE_IN = 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            lf = lfsr(lf);
            cnt[8*i +: 8] = lf[7:0];
            wr(ADDR_COUNT_BYTE0 + 16'(i), lf[7:0]);
        end
        u = cnt - 32'(cnt != 32'h0);
        chk("usb", cnt, USB_COUNT_OUT);
        chk("sec", 32'(cnt[17:9]), 32'(SECTOR_COUNTDOWN_OUT));
        @(negedge CLK_IN);
        {USB_BYTE_DONE_IN, SECTOR_DONE_IN} = 2'h3;
        @(negedge CLK_IN);
        {USB_BYTE_DONE_IN, SECTOR_DONE_IN} = 2'h0;
        chk("usbdec", u, USB_COUNT_OUT);
        chk("drv", cnt, DRIVE_COUNT_OUT);
        chk("secdec", 32'(cnt[17:9] - 9'(cnt[17:9] != 9'h0)), 32'(SECTOR_COUNTDOWN_OUT));
        for (int s = 0; s < 2; s++)
        begin
            COUNT_SET_READ_SELECT_IN = s[0];
            rd(ADDR_COUNT_BYTE2, s[0] ? cnt[23:16] : u[23:16]);
            rd(ADDR_COUNT_BYTE3, s[0] ? cnt[31:24] : u[31:24]);
        end
        {FULL_AUTO_EN_IN, ATAPI_DRIVE_IN, DRIVE_BUS_OUT_IN} = {2'h3, lfsr(lf)};
        wr(ADDR_CMD_LEN_CTRL, 8'h9f);
        rd(ADDR_CMD_LEN_CTRL, 8'h1f);
        chk("len", 32'h1f, 32'(COMMAND_PACKET_LENGTH_OUT));
        chk("last", 32'h1e, 32'(STAGE_LAST_OUT));
        chk("lvl", 32'(DRIVE_BUS_OUT_IN), 32'(lvl[15:0]));
        ATAPI_DRIVE_IN = 1'h0;
        #2;
        chk("len_ata", 32'h0, 32'(COMMAND_PACKET_LENGTH_OUT));
        chk("stage", 32'h10701, 32'({STAGE_USE_VALID_OUT, 3'h0, STAGE_LAST_OUT, 3'h0, STAGE_FIRST_OUT}));
        {FULL_AUTO_EN_IN, TRANS_STATE_IN} = 6'h03;
        wr(ADDR_CMD_LEN_CTRL, 8'h40);
        chk("abort_off", 32'h0, 32'(TRANSFER_ABORT_OUT));
        SEMI_AUTO_EN_IN = 1'h1;
        #2;
        chk("abort_on", 32'h1, 32'(TRANSFER_ABORT_OUT));
        rd(ADDR_CMD_LEN_CTRL, 8'h40);
        TRANS_STATE_IN = TRANS_IDLE;
        wr(ADDR_CMD_LEN_CTRL, 8'h20);
        chk("abort_clr", 32'h0, 32'(TRANSFER_ABORT_OUT));
        chk("rst_oe", 32'h0, 32'(DRIVE_RESET_OE_OUT));
        {DRIVE_HARD_RESET_CTRL_IN, DRIVE_BYTE_DONE_IN} = 2'h3;
        @(negedge CLK_IN);
        DRIVE_BYTE_DONE_IN = 1'h0;
        chk("rst_lvl", 32'h0, 32'(lvl[16]));
        chk("drvdec", u, DRIVE_COUNT_OUT);
        wr(16'h0000, 8'h5a);
        rd(16'h0000, 8'h00);
        PIO_MODE_IN = 1'h0;
        lf = lfsr(lf);
        wr(ADDR_COUNT_BYTE1, lf[7:0]);
        chk("merge", {u[31:16], lf[7:0], u[7:0]}, USB_COUNT_OUT);
        chk("sec_hold", 32'(cnt[17:9] - 9'(cnt[17:9] != 9'h0)), 32'(SECTOR_COUNTDOWN_OUT));
        @(negedge CLK_IN);
        stop_test;
    end
endmodule
